// ==== hdl/ecl_pkg.sv ====
// constants for the power-up configuration word loader of a four-port switch
// assumes words arrive already fetched from the serial memory, one per strobe
//
// How it works
// - word 66h bit 0 sets port 3 slot implemented flag
// - word 66h bit 1 sets port 3 connector clock flag
// - word 66h bit 2 sets port 3 device specific init flag
// - word 66h bit 3 sets port 3 low priority channel count
// - word 66h bits 6:4 set port 3 logical port number
// - word 66h bits 15:9 set port 3 traffic class to channel 0 map
// - words 70h..76h low byte sets base power of ports 0..3
// - power budget word bits 9:8 set the data scale field
// - power budget word bits 11:10 set the power state field
// - power budget word bit 15 sets the system allocated flag
// - words 80h, 82h bits 5:0 set power control fields of ports 0, 1
// - power control word bit 6 sets receive polarity disable
// - power control word bit 7 sets vga decode enable
// - power control word bits 15:8 set phy control bits 31:24
// - words 60h, 62h, 64h apply the slot word layout to ports 0..2
`default_nettype none
package ecl_pkg;

    localparam int NPORT = 4;
    localparam int NPMC  = 2;

    // ****************************************************************
    // word addresses in the configuration memory
    // ****************************************************************
    localparam logic [7:0] SLOT_WORD_BASE = 8'h60;
    localparam logic [7:0] PBUD_WORD_BASE = 8'h70;
    localparam logic [7:0] PMC_WORD_BASE  = 8'h80;
    localparam logic [7:0] WORD_STRIDE    = 8'h02;

    // ****************************************************************
    // bit positions inside the fetched words
    // ****************************************************************
    localparam int SLOT_IMPL_BIT = 0;
    localparam int CONN_CLK_BIT  = 1;
    localparam int DSI_BIT       = 2;
    localparam int LPC_BIT       = 3;
    localparam int PNUM_LSB      = 4;
    localparam int TCMAP_LSB     = 9;
    localparam int BPWR_LSB      = 0;
    localparam int DSCALE_LSB    = 8;
    localparam int PMST_LSB      = 10;
    localparam int SYSALLOC_BIT  = 15;
    localparam int PMCF_LSB      = 0;
    localparam int RXPOL_BIT     = 6;
    localparam int VGA_BIT       = 7;
    localparam int PHY_LSB       = 8;

    // ****************************************************************
    // values after reset (the fields' defaults)
    // ****************************************************************
    localparam logic [NPORT-1:0]   FLAG_RST  = 4'h0;
    localparam logic [3*NPORT-1:0] PNUM_RST  = 12'h000;
    localparam logic [7*NPORT-1:0] TCMAP_RST = 28'h0000000;
    localparam logic [8*NPORT-1:0] BPWR_RST  = 32'h00000000;
    localparam logic [2*NPORT-1:0] PAIR_RST  = 8'h00;
    localparam logic [6*NPMC-1:0]  PMCF_RST  = 12'h000;
    localparam logic [NPMC-1:0]    PMFL_RST  = 2'h0;
    localparam logic [8*NPMC-1:0]  PHY_RST   = 16'h0000;

    typedef enum logic [0:0] {
        ECL_LOAD,
        ECL_DONE
    } ecl_state_t;

    typedef struct packed {
        ecl_state_t           st;
        logic                 ready;
        logic [NPORT-1:0]     slot_impl;
        logic [NPORT-1:0]     conn_clk;
        logic [NPORT-1:0]     dsi_req;
        logic [NPORT-1:0]     lpc;
        logic [3*NPORT-1:0]   port_num;
        logic [7*NPORT-1:0]   tc_map;
        logic [8*NPORT-1:0]   base_pwr;
        logic [2*NPORT-1:0]   dscale;
        logic [2*NPORT-1:0]   pm_state;
        logic [NPORT-1:0]     sys_alloc;
        logic [6*NPMC-1:0]    pm_ctrl;
        logic [NPMC-1:0]      rx_pol_dis;
        logic [NPMC-1:0]      vga_en;
        logic [8*NPMC-1:0]    phy_ctl;
    } ecl_regs_t;

endpackage

`default_nettype wire

// ==== hdl/ecl_loader.sv ====
// configuration word loader: copies fetched words into per-port fields
// assumes an upstream fetcher presents one word per word_valid cycle
`timescale 1ns/100ps
`default_nettype none

module ecl_loader (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             word_valid,
    input  wire logic [7:0]                       word_addr,
    input  wire logic [15:0]                      word_data,
    input  wire logic                             load_done,
    output logic                                  cfg_ready,
    output logic [ecl_pkg::NPORT-1:0]             slot_impl,
    output logic [ecl_pkg::NPORT-1:0]             conn_clk,
    output logic [ecl_pkg::NPORT-1:0]             dsi_req,
    output logic [ecl_pkg::NPORT-1:0]             low_priority_channel_count,
    output logic [3*ecl_pkg::NPORT-1:0]           port_num,
    output logic [7*ecl_pkg::NPORT-1:0]           tc_map,
    output logic [8*ecl_pkg::NPORT-1:0]           base_pwr,
    output logic [2*ecl_pkg::NPORT-1:0]           data_scale,
    output logic [2*ecl_pkg::NPORT-1:0]           pm_state,
    output logic [ecl_pkg::NPORT-1:0]             sys_alloc,
    output logic [6*ecl_pkg::NPMC-1:0]            pm_ctrl,
    output logic [ecl_pkg::NPMC-1:0]              rx_pol_dis,
    output logic [ecl_pkg::NPMC-1:0]              vga_en,
    output logic [8*ecl_pkg::NPMC-1:0]            phy_control_word_five
);
    import ecl_pkg::*;

    ecl_regs_t        s_r;
    ecl_regs_t        s_nxt;
    logic [NPORT-1:0] slot_hit;
    logic [NPORT-1:0] pbud_hit;
    logic [NPMC-1:0]  pmc_hit;

    // ****************************************************************
    // word address decode, one comparator set per port
    // ****************************************************************
    genvar gp;
    generate
        for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_dec
            localparam logic [7:0] OFS = 8'(gp * 2);
            assign slot_hit[gp] = word_valid && (word_addr == SLOT_WORD_BASE + OFS);
            assign pbud_hit[gp] = word_valid && (word_addr == PBUD_WORD_BASE + OFS);
            // control words exist for two ports only
            // no comparator for ports 2, 3: words 84h, 86h are ignored
            if (gp < NPMC) begin : g_pmc
                assign pmc_hit[gp] = word_valid && (word_addr == PMC_WORD_BASE + OFS);
            end
        end
    endgenerate

    // ****************************************************************
    // next state: field copies and load sequencing
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            ECL_LOAD: begin
                for (int p = 0; p < NPORT; p++) begin
                    if (slot_hit[p]) begin
                        s_nxt.slot_impl[p] = word_data[SLOT_IMPL_BIT];
                        s_nxt.conn_clk[p]  = word_data[CONN_CLK_BIT];
                        s_nxt.dsi_req[p]   = word_data[DSI_BIT];
                        s_nxt.lpc[p]       = word_data[LPC_BIT];
                        s_nxt.port_num[3*p +: 3] = word_data[PNUM_LSB +: 3];
                        s_nxt.tc_map[7*p +: 7]   = word_data[TCMAP_LSB +: 7];
                    end
                    if (pbud_hit[p]) begin
                        s_nxt.base_pwr[8*p +: 8] = word_data[BPWR_LSB +: 8];
                        s_nxt.dscale[2*p +: 2]   = word_data[DSCALE_LSB +: 2];
                        s_nxt.pm_state[2*p +: 2] = word_data[PMST_LSB +: 2];
                        s_nxt.sys_alloc[p]       = word_data[SYSALLOC_BIT];
                    end
                end
                for (int q = 0; q < NPMC; q++) begin
                    if (pmc_hit[q]) begin
                        s_nxt.pm_ctrl[6*q +: 6] = word_data[PMCF_LSB +: 6];
                        s_nxt.rx_pol_dis[q]     = word_data[RXPOL_BIT];
                        s_nxt.vga_en[q]         = word_data[VGA_BIT];
                        s_nxt.phy_ctl[8*q +: 8] = word_data[PHY_LSB +: 8];
                    end
                end
                if (load_done) begin
                    s_nxt.st    = ECL_DONE;
                    s_nxt.ready = 1'b1;
                end
            end
            // fields frozen once ports may answer requests
            ECL_DONE: begin
                s_nxt.ready = 1'b1;
            end
            default: begin
                s_nxt.st = ECL_LOAD;
            end
        endcase
    end

    // ****************************************************************
    // state register with defaults on reset
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r.st         <= ECL_LOAD;
            s_r.ready      <= 1'b0;
            s_r.slot_impl  <= FLAG_RST;
            s_r.conn_clk   <= FLAG_RST;
            s_r.dsi_req    <= FLAG_RST;
            s_r.lpc        <= FLAG_RST;
            s_r.port_num   <= PNUM_RST;
            s_r.tc_map     <= TCMAP_RST;
            s_r.base_pwr   <= BPWR_RST;
            s_r.dscale     <= PAIR_RST;
            s_r.pm_state   <= PAIR_RST;
            s_r.sys_alloc  <= FLAG_RST;
            s_r.pm_ctrl    <= PMCF_RST;
            s_r.rx_pol_dis <= PMFL_RST;
            s_r.vga_en     <= PMFL_RST;
            s_r.phy_ctl    <= PHY_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs are the flip-flops themselves
    assign cfg_ready                  = s_r.ready;
    assign slot_impl                  = s_r.slot_impl;
    assign conn_clk                   = s_r.conn_clk;
    assign dsi_req                    = s_r.dsi_req;
    assign low_priority_channel_count = s_r.lpc;
    assign port_num                   = s_r.port_num;
    assign tc_map                     = s_r.tc_map;
    assign base_pwr                   = s_r.base_pwr;
    assign data_scale                 = s_r.dscale;
    assign pm_state                   = s_r.pm_state;
    assign sys_alloc                  = s_r.sys_alloc;
    assign pm_ctrl                    = s_r.pm_ctrl;
    assign rx_pol_dis                 = s_r.rx_pol_dis;
    assign vga_en                     = s_r.vga_en;
    assign phy_control_word_five      = s_r.phy_ctl;

endmodule

`default_nettype wire

// ==== tb/ecl_mem_model.sv ====
// memory side model: presents one fetched word per cycle when asked
// assumes the bench raises req just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module ecl_mem_model (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic [7:0]  req_addr,
    input  wire logic [15:0] req_data,
    output logic             word_valid,
    output logic [7:0]       word_addr,
    output logic [15:0]      word_data
);
    initial {word_valid, word_addr, word_data} = 25'h0;
    // absent words: idle lines toggle, so every second idle cycle shows the last word again
    always @(negedge clk) begin
        word_valid <= req;
        word_addr  <= req ? req_addr : ~word_addr;
        word_data  <= req ? req_data : ~word_data;
    end
endmodule
`default_nettype wire

// ==== tb/ecl_loader_sva.sv ====
// port checker for the word loader, bound to its top module
// assumes one clock, synchronous active high reset
`timescale 1ns/100ps
`default_nettype none
module ecl_loader_chk (
    input wire logic        clk, rst, word_valid, load_done, cfg_ready,
    input wire logic [7:0]  word_addr,
    input wire logic [15:0] word_data, phy_control_word_five,
    input wire logic [3:0]  slot_impl, conn_clk, dsi_req, low_priority_channel_count,
    input wire logic [3:0]  sys_alloc,
    input wire logic [11:0] port_num, pm_ctrl,
    input wire logic [27:0] tc_map,
    input wire logic [31:0] base_pwr,
    input wire logic [7:0]  data_scale, pm_state,
    input wire logic [1:0]  rx_pol_dis, vga_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // a word the loader must take at this edge
    sequence s_take(logic [7:0] a);
        word_valid && !cfg_ready && word_addr == a;
    endsequence
    a_slot_flags:
    assert property (s_take(8'h66) |=> {low_priority_channel_count[3], dsi_req[3],
        conn_clk[3], slot_impl[3]} == $past(word_data[3:0])) else $error("port 3 flags");
    a_port_number:
    assert property (s_take(8'h66) |=> port_num[11:9] == $past(word_data[6:4]))
        else $error("port 3 number");
    a_tc_map:
    assert property (s_take(8'h66) |=> tc_map[27:21] == $past(word_data[15:9]))
        else $error("port 3 map");
    a_port0_slot:
    assert property (s_take(8'h60) |=> slot_impl[0] == $past(word_data[0])
        && tc_map[6:0] == $past(word_data[15:9])) else $error("port 0 slot word");
    a_base_power:
    assert property (s_take(8'h70) |=> base_pwr[7:0] == $past(word_data[7:0]))
        else $error("base power");
    a_budget_fields:
    assert property (s_take(8'h76) |=> {sys_alloc[3], pm_state[7:6], data_scale[7:6]}
        == $past({word_data[15], word_data[11:8]})) else $error("budget fields");
    a_power_ctrl:
    assert property (s_take(8'h80) |=> {rx_pol_dis[0], pm_ctrl[5:0]}
        == $past(word_data[6:0])) else $error("power control");
    a_vga_phy:
    assert property (s_take(8'h82) |=> {phy_control_word_five[15:8], vga_en[1]}
        == $past(word_data[15:7])) else $error("vga or phy");
    a_done_ready:
    assert property (load_done && !cfg_ready |=> cfg_ready [*3]) else $error("ready late");
    a_no_early:
    assert property (!cfg_ready && !load_done |=> !cfg_ready) else $error("ready early");
    a_frozen:
    assert property (cfg_ready |=> $stable(base_pwr) && $stable(tc_map))
        else $error("fields moved after ready");
endmodule
bind ecl_loader ecl_loader_chk ecl_loader_chk_inst (.clk, .rst, .word_valid, .load_done,
    .cfg_ready, .word_addr, .word_data, .phy_control_word_five, .slot_impl, .conn_clk,
    .dsi_req, .low_priority_channel_count, .sys_alloc, .port_num, .pm_ctrl, .tc_map,
    .base_pwr, .data_scale, .pm_state, .rx_pol_dis, .vga_en);
`default_nettype wire

// ==== tb/ecl_loader_test.sv ====
// bench for the word loader: corner and random words against a reference
// assumes the memory model feeds the loader and the checker is bound
`timescale 1ns/100ps
`default_nettype none
module ecl_loader_test;
    import ecl_pkg::*;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, load_done = 1'b0, go = 1'b0, e_rdy;
    logic [7:0] req_addr = 8'h00, word_addr, data_scale, pm_state, e_dsc, e_pms;
    logic [15:0] req_data = 16'h0000, word_data, phy_control_word_five, e_phy;
    logic word_valid, cfg_ready;
    logic [3:0] slot_impl, conn_clk, dsi_req, low_priority_channel_count, sys_alloc;
    logic [3:0] e_slot, e_clk, e_dsi, e_lpc, e_sys;
    logic [1:0] rx_pol_dis, vga_en, e_rxp, e_vga;
    logic [11:0] port_num, pm_ctrl, e_pnum, e_pmc;
    logic [27:0] tc_map, e_tc;
    logic [31:0] base_pwr, e_bp, lfsr = 32'h249a;
    logic [7:0] tbl [12] = '{8'h60, 8'h62, 8'h64, 8'h66, 8'h70, 8'h72, 8'h74, 8'h76,
        8'h80, 8'h82, 8'h84, 8'h86};
    int fail_count = 0, check_count = 0;
    always #12.5 clk = ~clk;
    ecl_mem_model ecl_mem_model_inst (.clk, .req, .req_addr, .req_data, .word_valid,
        .word_addr, .word_data);
    ecl_loader ecl_loader_inst (.clk, .rst, .word_valid, .word_addr, .word_data,
        .load_done, .cfg_ready, .slot_impl, .conn_clk, .dsi_req,
        .low_priority_channel_count, .port_num, .tc_map, .base_pwr, .data_scale,
        .pm_state, .sys_alloc, .pm_ctrl, .rx_pol_dis, .vga_en, .phy_control_word_five);
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    // expected field update for one taken word
    task automatic apply(input logic [7:0] a, input logic [15:0] d);
        int p;
        p = a[2:1];
        case (a)
            8'h60, 8'h62, 8'h64, 8'h66: begin
                {e_lpc[p], e_dsi[p], e_clk[p], e_slot[p]} = d[3:0];
                e_pnum[3*p+:3] = d[6:4];
                e_tc[7*p+:7] = d[15:9];
            end
            8'h70, 8'h72, 8'h74, 8'h76:
                {e_sys[p], e_pms[2*p+:2], e_dsc[2*p+:2], e_bp[8*p+:8]} = {d[15], d[11:0]};
            8'h80, 8'h82: {e_phy[8*p+:8], e_vga[p], e_rxp[p], e_pmc[6*p+:6]} = d;
            default: ;
        endcase
    endtask
    task automatic check_all();
        check("ready", cfg_ready, e_rdy);
        check("slot", {low_priority_channel_count, dsi_req, conn_clk, slot_impl},
            {e_lpc, e_dsi, e_clk, e_slot});
        check("pnum", port_num, e_pnum);
        check("tcmap", tc_map, e_tc);
        check("bpwr", base_pwr, e_bp);
        check("budget", {data_scale, pm_state, sys_alloc}, {e_dsc, e_pms, e_sys});
        check("pmc", {rx_pol_dis, pm_ctrl}, {e_rxp, e_pmc});
        check("phy", {vga_en, phy_control_word_five}, {e_vga, e_phy});
    endtask
    task automatic word(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {req, req_addr, req_data} <= {1'b1, a, d};
    endtask
    // random words back to back, some idle cycles, reserved places mixed in
    task automatic burst(input int n);
        repeat (n) begin
            lfsr = nxt(lfsr);
            // one assignment per edge: idle cycles come from the valid bit itself
            @(posedge clk);
            {req, req_addr, req_data} <= {lfsr[3] | lfsr[4], tbl[lfsr[31:16] % 12],
                lfsr[15:0]};
        end
        @(posedge clk);
        req <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // reference model follows the words the loader ought to take
    always @(posedge clk) begin
        if (rst) begin
            {e_slot, e_clk, e_dsi, e_lpc, e_sys, e_rxp, e_vga, e_pnum, e_pmc} = '0;
            {e_tc, e_bp, e_dsc, e_pms, e_phy, e_rdy} = '0;
        end else begin
            if (word_valid && !e_rdy) apply(word_addr, word_data);
            if (load_done) e_rdy = 1'b1;
        end
    end
    // compare mid cycle so both sides have settled
    always @(negedge clk) if (go) check_all();
    initial begin
        #50000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        go = 1'b1;
        // overwrite, reserved place, all ones on a control word
        word(8'h66, 16'hffff);
        word(8'h66, 16'h0000);
        word(8'h86, 16'hffff);
        word(8'h82, 16'hffff);
        burst(200);
        $display("corner and random words done");
        // last word lands with the done strobe, later words are ignored
        word(8'h70, 16'ha5c3);
        @(negedge clk);
        load_done = 1'b1;
        @(negedge clk);
        load_done = 1'b0;
        burst(30);
        $display("done strobe and freeze done");
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        burst(20);
        $display("second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
